// ===== common/wmcat_pkg.sv
`default_nettype none
package wmcat_pkg;

  // ==========================================================
  // Dimensions
  localparam int NUM_AC     = 4;
  localparam int AC_W       = 2;
  localparam int BO_W       = 10;
  localparam int IFS_W      = 10;
  localparam int NAV_W      = 16;
  localparam int TSF_W      = 64;
  localparam int SLEEP_W    = 32;
  localparam int NUM_TRIG   = 2;

  // ==========================================================
  // Timing, 40 MHz system clock
  localparam int  CLK_MHZ        = 40;
  localparam int  US_TIME        = 1;
  localparam int  US_CYCLES      = US_TIME * CLK_MHZ;
  localparam int  SLOT_US        = 9;
  localparam int  SIFS_US        = 10;
  localparam int  RIFS_US        = 2;
  localparam logic [IFS_W-1:0] SLOT_CYC = IFS_W'(SLOT_US * US_CYCLES);
  localparam logic [IFS_W-1:0] SIFS_CYC = IFS_W'(SIFS_US * US_CYCLES);
  localparam logic [IFS_W-1:0] RIFS_CYC = IFS_W'(RIFS_US * US_CYCLES);
  localparam logic [5:0]       US_DIV   = 6'(US_CYCLES - 1);

  // ==========================================================
  // Reset values
  localparam logic [2:0] COEX_PIN_MODE_RST = 3'h7;
  localparam logic       COEX_FREQ_SEL_RST = 1'h0;

  // ==========================================================
  // Enumerations and carriers
  typedef enum logic { WMCAT_POL_FIXED, WMCAT_POL_ROUND } wmcat_policy_t;
  typedef enum logic [1:0] { WMCAT_TX_NONE, WMCAT_TX_SIFS, WMCAT_TX_RIFS, WMCAT_TX_BO }
    wmcat_txkind_t;

  typedef struct packed {
    logic             load;
    logic [AC_W-1:0]  ac;
    logic [BO_W-1:0]  count;
  } wmcat_bo_load_t;

  typedef struct packed {
    logic             sched;
    logic [AC_W-1:0]  queue;
    logic             use_sifs;
    logic             use_rifs;
  } wmcat_tx_req_t;

  typedef struct packed {
    logic             start;
    logic [AC_W-1:0]  queue;
    wmcat_txkind_t    kind;
  } wmcat_tx_go_t;

  typedef struct packed {
    logic             load;
    logic [TSF_W-1:0] stamp;
  } wmcat_tsf_load_t;

endpackage : wmcat_pkg
`default_nettype wire

// ===== logic/wmcat_backoff.sv
`timescale 1ns/100ps
`default_nettype none
module wmcat_backoff
(
  input  wire logic                          clk_sys_i,
  input  wire logic                          rst_i,
  input  wire logic                          slot_end_i,
  input  wire logic                          idle_i,
  input  wire logic                          load_i,
  input  wire logic [wmcat_pkg::BO_W-1:0]    count_i,
  input  wire logic                          clear_i,
  output logic                               zero_o
);

  logic [wmcat_pkg::BO_W-1:0] count;
  logic                       armed;
  wire                        dec_en = armed && slot_end_i && idle_i && (count != '0);

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || clear_i)
    begin
      count <= '0;
      armed <= 1'b0;
    end
    else if (load_i)
    begin
      count <= count_i;
      armed <= 1'b1;
    end
    else if (dec_en)
      count <= count - 1'b1;
  end

  // Reaching zero flags the category until the engine clears it
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      zero_o <= 1'b0;
    else
      zero_o <= armed && !clear_i && !load_i && (count == '0);
  end

endmodule : wmcat_backoff
`default_nettype wire

// ===== logic/wmcat_top.sv
`timescale 1ns/100ps
`default_nettype none
// Contract
// - INTERFRAME_TIMING_UNIT timers start when channel activity ends
// - Back-off counts idle slots, pauses when busy
// - Zero back-off notifies the transmit engine
// - Simultaneous zeros grant exactly one, by policy
// - Engine picks queue from channel-access info
// - Scheduled frame starts only on timing trigger
// - SIFS/RIFS triggers drive responses and bursts
// - Sleep timer on slow tick wakes MAC
// - TSF advanced by elapsed sleep on wake
// - TSF loads beacon timestamps on command
// - Track TBTT, pulse programmed offset triggers
// - NAV from duration, nonzero means virtual busy
// - Drive tx permit, accept peer coexistence inputs
// - Three pins coex default; freq pin GPIO default
module wmcat_top
(
  input  wire logic                              clk_sys_i,
  input  wire logic                              rst_i,
  input  wire logic                              phy_busy_i,
  input  wire logic                              slow_tick_i,
  input  wire wmcat_pkg::wmcat_bo_load_t         bo_load_i,
  input  wire wmcat_pkg::wmcat_policy_t          policy_i,
  input  wire logic                              grant_ack_i,
  input  wire wmcat_pkg::wmcat_tx_req_t          tx_req_i,
  input  wire logic                              nav_upd_i,
  input  wire logic [wmcat_pkg::NAV_W-1:0]       nav_dur_i,
  input  wire wmcat_pkg::wmcat_tsf_load_t        tsf_load_i,
  input  wire logic [wmcat_pkg::TSF_W-1:0]       tbtt_i,
  input  wire logic [wmcat_pkg::TSF_W-1:0]       beacon_int_i,
  input  wire logic [wmcat_pkg::TSF_W-1:0]       trig_off_i [wmcat_pkg::NUM_TRIG],
  input  wire logic                              sleep_go_i,
  input  wire logic [wmcat_pkg::SLEEP_W-1:0]     sleep_cnt_i,
  input  wire logic [2:0]                        coex_pin_mode_i,
  input  wire logic                              coex_freq_sel_i,
  input  wire logic                              coex_mode_wr_i,
  input  wire logic                              coex_permit_i,
  input  wire logic                              coex_priority_direction_i,
  input  wire logic                              coex_peer_active_i,
  input  wire logic                              coex_restricted_channel_i,
  output logic [wmcat_pkg::NUM_AC-1:0]           bo_grant_o,
  output logic                                   sifs_trig_o,
  output logic                                   rifs_trig_o,
  output logic                                   slot_trig_o,
  output wmcat_pkg::wmcat_tx_go_t                tx_go_o,
  output logic                                   nav_busy_o,
  output logic                                   medium_idle_o,
  output logic [wmcat_pkg::TSF_W-1:0]            tsf_o,
  output logic                                   tbtt_o,
  output logic [wmcat_pkg::NUM_TRIG-1:0]         trig_o,
  output logic                                   mac_clk_en_o,
  output logic                                   wake_o,
  output logic                                   coex_tx_permit_o,
  output logic [2:0]                             coex_pin_mode_o,
  output logic                                   coex_freq_sel_o,
  output logic [2:0]                             coex_status_o
);

  // ==========================================================
  // Pin synchronisers
  logic [1:0] busy_s;
  logic [1:0] tick_s;
  logic [1:0] prio_s;
  logic [1:0] act_s;
  logic [1:0] freq_s;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      busy_s <= '0;
      tick_s <= '0;
      prio_s <= '0;
      act_s  <= '0;
      freq_s <= '0;
    end
    else
    begin
      busy_s <= {busy_s[0], phy_busy_i};
      tick_s <= {tick_s[0], slow_tick_i};
      prio_s <= {prio_s[0], coex_priority_direction_i};
      act_s  <= {act_s[0], coex_peer_active_i};
      freq_s <= {freq_s[0], coex_restricted_channel_i};
    end
  end

  wire busy_q = busy_s[1];
  logic busy_d;
  logic tick_d;
  wire phy_end   = busy_d && !busy_q;
  wire slow_edge = tick_s[1] && !tick_d;

  // ==========================================================
  // Microsecond divider and NAV
  logic [5:0]                  us_cnt;
  logic [wmcat_pkg::NAV_W-1:0] nav;
  wire us_tick  = (us_cnt == wmcat_pkg::US_DIV);
  wire nav_nz   = (nav != '0);
  wire idle_now = !busy_q && !nav_nz;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      us_cnt <= '0;
      nav    <= '0;
      busy_d <= 1'b0;
      tick_d <= 1'b0;
    end
    else
    begin
      us_cnt <= us_tick ? '0 : us_cnt + 1'b1;
      busy_d <= busy_q;
      tick_d <= tick_s[1];
      if (nav_upd_i && nav_dur_i > nav)
        nav <= nav_dur_i;
      else if (us_tick && nav_nz)
        nav <= nav - 1'b1;
    end
  end

  // ==========================================================
  // Interframe timers
  logic [wmcat_pkg::IFS_W-1:0] ifs_cnt;
  logic                        ifs_run;
  logic [wmcat_pkg::IFS_W-1:0] slot_cnt;
  wire sifs_hit = ifs_run && (ifs_cnt == wmcat_pkg::SIFS_CYC - 1'b1);
  wire rifs_hit = ifs_run && (ifs_cnt == wmcat_pkg::RIFS_CYC - 1'b1);
  wire slot_end = idle_now && (slot_cnt == wmcat_pkg::SLOT_CYC - 1'b1);

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || busy_q)
    begin
      ifs_cnt  <= '0;
      ifs_run  <= 1'b0;
      slot_cnt <= '0;
    end
    else
    begin
      if (phy_end)
      begin
        ifs_cnt <= '0;
        ifs_run <= 1'b1;
      end
      else if (sifs_hit)
        ifs_run <= 1'b0;
      else if (ifs_run)
        ifs_cnt <= ifs_cnt + 1'b1;
      // Slot phase restarts whenever the virtual carrier is busy
      if (!idle_now || slot_end)
        slot_cnt <= '0;
      else
        slot_cnt <= slot_cnt + 1'b1;
    end
  end

  // ==========================================================
  // Back-off engines and arbitration
  logic [wmcat_pkg::NUM_AC-1:0] bo_zero;
  logic [wmcat_pkg::NUM_AC-1:0] bo_clear;
  logic [wmcat_pkg::AC_W-1:0]   rr_ptr;
  logic                         grant_hold;

  genvar g;
  generate
    for (g = 0; g < wmcat_pkg::NUM_AC; g++)
    begin : g_bo
      wire ld = bo_load_i.load && (bo_load_i.ac == wmcat_pkg::AC_W'(g));
      wmcat_backoff u_bo
      (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .slot_end_i(slot_end),
        .idle_i    (idle_now),
        .load_i    (ld),
        .count_i   (bo_load_i.count),
        .clear_i   (bo_clear[g]),
        .zero_o    (bo_zero[g])
      );
    end
  endgenerate

  // Last requester in rotated order from the start wins; fixed policy starts at 0
  function automatic logic [wmcat_pkg::NUM_AC-1:0] pick_one
  (
    input logic [wmcat_pkg::NUM_AC-1:0] req,
    input logic [wmcat_pkg::AC_W-1:0]   start
  );
    logic [wmcat_pkg::NUM_AC-1:0] res;
    logic [wmcat_pkg::AC_W-1:0]   idx;
    res = '0;
    for (int i = 0; i < wmcat_pkg::NUM_AC; i++)
    begin
      idx = start + wmcat_pkg::AC_W'(i);
      if (req[idx])
        res = '0;
      if (req[idx])
        res[idx] = 1'b1;
    end
    return res;
  endfunction : pick_one

  wire [wmcat_pkg::AC_W-1:0]   arb_start =
    (policy_i == wmcat_pkg::WMCAT_POL_ROUND) ? rr_ptr : '0;
  wire [wmcat_pkg::NUM_AC-1:0] arb_win = pick_one(bo_zero, arb_start);
  assign bo_clear = grant_ack_i ? bo_grant_o : '0;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      bo_grant_o <= '0;
      grant_hold <= 1'b0;
      rr_ptr     <= '0;
    end
    else if (grant_ack_i || !grant_hold)
    begin
      // Grant stays put until acknowledged, so the engine sees a stable choice
      bo_grant_o <= grant_ack_i ? '0 : arb_win;
      grant_hold <= !grant_ack_i && (arb_win != '0);
      if (grant_ack_i)
        rr_ptr <= rr_ptr + 1'b1;
    end
  end

  // ==========================================================
  // Transmit trigger
  wmcat_pkg::wmcat_tx_req_t pend;
  wire bo_ok  = |(bo_grant_o & (wmcat_pkg::NUM_AC'(1) << pend.queue));
  wire go_now = pend.sched && ((pend.use_rifs && rifs_hit) ||
                (pend.use_sifs && sifs_hit) ||
                (!pend.use_sifs && !pend.use_rifs && bo_ok));
  wire wmcat_pkg::wmcat_txkind_t go_kind =
    pend.use_rifs ? wmcat_pkg::WMCAT_TX_RIFS :
    pend.use_sifs ? wmcat_pkg::WMCAT_TX_SIFS : wmcat_pkg::WMCAT_TX_BO;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      pend    <= '0;
      tx_go_o <= '0;
    end
    else
    begin
      tx_go_o.start <= go_now;
      tx_go_o.queue <= pend.queue;
      tx_go_o.kind  <= go_now ? go_kind : wmcat_pkg::WMCAT_TX_NONE;
      if (tx_req_i.sched)
        pend <= tx_req_i;
      else if (go_now)
        pend.sched <= 1'b0;
    end
  end

  // ==========================================================
  // TSF, TBTT, offset triggers and sleep
  logic [wmcat_pkg::TSF_W-1:0]   tsf;
  logic [wmcat_pkg::TSF_W-1:0]   tbtt_next;
  logic [wmcat_pkg::SLEEP_W-1:0] sleep_left;
  logic [wmcat_pkg::SLEEP_W-1:0] sleep_len;
  logic                          asleep;
  wire sleep_done = asleep && slow_edge && (sleep_left <= 1);

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      tsf        <= '0;
      tbtt_next  <= '0;
      tbtt_o     <= 1'b0;
      trig_o     <= '0;
      asleep     <= 1'b0;
      sleep_left <= '0;
      sleep_len  <= '0;
      wake_o     <= 1'b0;
    end
    else
    begin
      wake_o <= sleep_done;
      if (tsf_load_i.load)
        tsf <= tsf_load_i.stamp;
      else if (sleep_done)
        tsf <= tsf + wmcat_pkg::TSF_W'(sleep_len);
      else if (us_tick && !asleep)
        tsf <= tsf + 1'b1;
      tbtt_o <= !asleep && (tsf == tbtt_next);
      if (tsf == tbtt_next && !asleep)
        tbtt_next <= tbtt_next + beacon_int_i;
      else if (tbtt_next < tbtt_i || tsf_load_i.load)
        tbtt_next <= tbtt_i;
      // Offsets count from the last target, since the next one has already moved on
      for (int t = 0; t < wmcat_pkg::NUM_TRIG; t++)
        trig_o[t] <= us_tick && (tsf == tbtt_next - beacon_int_i + trig_off_i[t]);
      if (sleep_go_i && !asleep)
      begin
        asleep     <= 1'b1;
        sleep_left <= sleep_cnt_i;
        sleep_len  <= sleep_cnt_i;
      end
      else if (sleep_done)
        asleep <= 1'b0;
      else if (asleep && slow_edge)
        sleep_left <= sleep_left - 1'b1;
    end
  end

  // ==========================================================
  // Status outputs and coexistence
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      sifs_trig_o      <= 1'b0;
      rifs_trig_o      <= 1'b0;
      slot_trig_o      <= 1'b0;
      nav_busy_o       <= 1'b0;
      medium_idle_o    <= 1'b0;
      tsf_o            <= '0;
      mac_clk_en_o     <= 1'b1;
      coex_tx_permit_o <= 1'b0;
      coex_pin_mode_o  <= wmcat_pkg::COEX_PIN_MODE_RST;
      coex_freq_sel_o  <= wmcat_pkg::COEX_FREQ_SEL_RST;
      coex_status_o    <= '0;
    end
    else
    begin
      sifs_trig_o   <= sifs_hit;
      rifs_trig_o   <= rifs_hit;
      slot_trig_o   <= slot_end;
      nav_busy_o    <= nav_nz;
      medium_idle_o <= idle_now;
      tsf_o         <= tsf;
      mac_clk_en_o  <= !(asleep && !sleep_done);
      // Permit only while the pin is in coexistence use
      coex_tx_permit_o <= coex_permit_i && coex_pin_mode_o[0];
      coex_status_o <= {freq_s[1] && coex_freq_sel_o,
                        act_s[1] && coex_pin_mode_o[2],
                        prio_s[1] && coex_pin_mode_o[1]};
      if (coex_mode_wr_i)
      begin
        coex_pin_mode_o <= coex_pin_mode_i;
        coex_freq_sel_o <= coex_freq_sel_i;
      end
    end
  end

endmodule : wmcat_top
`default_nettype wire

// ===== verification/wmcat_phy_model.sv
`timescale 1ns/100ps
`default_nettype none
module wmcat_phy_model
(
  input  wire logic        clk_sys_i,
  input  wire logic        burst_i,
  input  wire logic [15:0] len_i,
  input  wire logic [2:0]  peer_i,
  output logic             busy_o,
  output logic [2:0]       peer_o,
  output logic             slow_o
);
  logic [15:0] left = 16'h0;
  logic [3:0]  div  = 4'h0;
  initial
  begin
    busy_o = 1'b0;
    peer_o = 3'h0;
    slow_o = 1'b0;
  end
  // ==========================================================
  // Channel activity, then end of activity
  always @(posedge clk_sys_i)
  begin
    left   <= burst_i ? len_i : (left != 16'h0 ? left - 16'h1 : 16'h0);
    busy_o <= burst_i || left > 16'h1;
    peer_o <= peer_i;
    div    <= div + 4'h1;
    slow_o <= div[3];
  end
endmodule : wmcat_phy_model
`default_nettype wire

// ===== verification/wmcat_top_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module wmcat_checker
(
  input wire logic                           clk_sys_i,
  input wire logic                           rst_i,
  input wire logic                           phy_busy_i,
  input wire logic                           grant_ack_i,
  input wire logic                           nav_upd_i,
  input wire logic [wmcat_pkg::NAV_W-1:0]    nav_dur_i,
  input wire logic [2:0]                     coex_pin_mode_i,
  input wire logic                           coex_mode_wr_i,
  input wire logic [wmcat_pkg::NUM_AC-1:0]   bo_grant_o,
  input wire logic                           sifs_trig_o,
  input wire logic                           rifs_trig_o,
  input wire wmcat_pkg::wmcat_tx_go_t        tx_go_o,
  input wire logic                           nav_busy_o,
  input wire logic [2:0]                     coex_pin_mode_o,
  input wire logic                           coex_freq_sel_o,
  input wire logic                           wake_o,
  input wire logic                           tbtt_o
);
  // ==========================================================
  // Properties
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Channel quiet for a while, so no restart muddies the count
  sequence s_quiet;
    $fell(phy_busy_i) ##1 !phy_busy_i [*8];
  endsequence
  property p_sifs; s_quiet |-> ##[390:400] sifs_trig_o; endproperty
  property p_rifs; s_quiet |-> ##[70:80] rifs_trig_o; endproperty
  property p_onehot; $onehot0(bo_grant_o); endproperty
  property p_hold; bo_grant_o != 4'h0 && !grant_ack_i |=> $stable(bo_grant_o); endproperty
  property p_txgo;
    tx_go_o.start && tx_go_o.kind == wmcat_pkg::WMCAT_TX_BO |-> $past(bo_grant_o) != 4'h0;
  endproperty
  property p_nav; nav_upd_i && nav_dur_i != 16'h0 |-> ##[1:3] nav_busy_o; endproperty
  property p_rst; $fell(rst_i) |-> coex_pin_mode_o == 3'h7 && !coex_freq_sel_o; endproperty
  property p_mode; coex_mode_wr_i |=> coex_pin_mode_o == $past(coex_pin_mode_i); endproperty
  property p_wake; wake_o |=> !wake_o; endproperty
  property p_tbtt; tbtt_o |=> !tbtt_o; endproperty
  // ==========================================================
  // Assertions
  a_sifs: assert property (p_sifs) else $error("sifs trigger off time");
  a_rifs: assert property (p_rifs) else $error("rifs trigger off time");
  a_onehot: assert property (p_onehot) else $error("several grants");
  a_hold: assert property (p_hold) else $error("grant moved before ack");
  a_txgo: assert property (p_txgo) else $error("start without grant");
  a_nav: assert property (p_nav) else $error("nav not busy");
  a_rst: assert property (p_rst) else $error("pin mode reset wrong");
  a_mode: assert property (p_mode) else $error("pin mode not loaded");
  a_wake: assert property (p_wake) else $error("wake not a pulse");
  a_tbtt: assert property (p_tbtt) else $error("tbtt not a pulse");
endmodule : wmcat_checker
`default_nettype wire

// ===== verification/wmcat_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module wmcat_top_tb_top;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic burst, slow, bsy, ack, nupd, sgo, mwr, permit, fsel;
  logic sifs, rifs, slot, navb, midle, tbo, clken, wake, txp, fso;
  logic [15:0] blen, ndur;
  logic [2:0]  peer_cmd, peer, mode, mo, st;
  logic [3:0]  grant, g;
  logic [1:0]  trig;
  logic [63:0] tbtt, tsf, b;
  logic [63:0] toff [2];
  logic [31:0] scnt;
  int          checked = 0;
  int          bad_count = 0;
  int          cyc = 0;
  wmcat_pkg::wmcat_bo_load_t  bol;
  wmcat_pkg::wmcat_tx_req_t   txr;
  wmcat_pkg::wmcat_tsf_load_t tsl;
  wmcat_pkg::wmcat_tx_go_t    go;
  wmcat_pkg::wmcat_policy_t   pol;
  always #12.5 clk_sys_i = ~clk_sys_i;
  wmcat_phy_model wmcat_phy_model_inst (.clk_sys_i(clk_sys_i), .burst_i(burst),
    .len_i(blen), .peer_i(peer_cmd), .busy_o(bsy), .peer_o(peer), .slow_o(slow));
  wmcat_top wmcat_top_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .phy_busy_i(bsy),
    .slow_tick_i(slow), .bo_load_i(bol), .policy_i(pol),
    .grant_ack_i(ack), .tx_req_i(txr), .nav_upd_i(nupd), .nav_dur_i(ndur),
    .tsf_load_i(tsl), .tbtt_i(tbtt), .beacon_int_i(64'h64), .trig_off_i(toff),
    .sleep_go_i(sgo), .sleep_cnt_i(scnt), .coex_pin_mode_i(mode), .coex_freq_sel_i(fsel),
    .coex_mode_wr_i(mwr), .coex_permit_i(permit), .coex_priority_direction_i(peer[0]),
    .coex_peer_active_i(peer[1]), .coex_restricted_channel_i(peer[2]),
    .bo_grant_o(grant), .sifs_trig_o(sifs), .rifs_trig_o(rifs), .slot_trig_o(slot),
    .tx_go_o(go), .nav_busy_o(navb), .medium_idle_o(midle), .tsf_o(tsf), .tbtt_o(tbo),
    .trig_o(trig), .mac_clk_en_o(clken), .wake_o(wake), .coex_tx_permit_o(txp),
    .coex_pin_mode_o(mo), .coex_freq_sel_o(fso), .coex_status_o(st));
  // ==========================================================
  // Shared tasks
  task cmp(input string nm, input logic [63:0] e, input logic [63:0] v);
    checked++;
    if (v !== e)
    begin
      bad_count++;
      $display("unexpected %s exp %0h got %0h", nm, e, v);
    end
  endtask : cmp
  task complete_run;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task do_reset;
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
  endtask : do_reset
  task give_ack;
    ack <= 1'b1;
    @(posedge clk_sys_i);
    ack <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
  endtask : give_ack
  task load(input logic [1:0] ac, input logic [9:0] n);
    bol <= '{1'b1, ac, n};
    @(posedge clk_sys_i);
    bol <= '0;
    @(posedge clk_sys_i);
  endtask : load
  // ==========================================================
  // Scenarios
  task t_ifs;
    int n;
    burst <= 1'b1;
    blen  <= 16'h0032;
    @(posedge clk_sys_i);
    burst <= 1'b0;
    for (n = 0; n < 1000 && rifs !== 1'b1; n++)
      @(posedge clk_sys_i);
    @(posedge clk_sys_i);
    for (n = 1; n < 1000 && sifs !== 1'b1; n++)
      @(posedge clk_sys_i);
    cmp("sifs_gap", 64'(wmcat_pkg::SIFS_CYC - wmcat_pkg::RIFS_CYC), 64'(n));
  endtask : t_ifs
  task t_bo;
    txr <= '{1'b1, 2'h1, 1'b0, 1'b0};
    load(2'h1, 10'h002);
    txr <= '0;
    repeat (3000) if (go.start !== 1'b1) @(posedge clk_sys_i);
    cmp("go_start", 64'h1, 64'(go.start));
    cmp("go_queue", 64'h1, 64'(go.queue));
    cmp("go_kind", 64'(wmcat_pkg::WMCAT_TX_BO), 64'(go.kind));
    cmp("grant", 64'h2, 64'(grant));
    give_ack();
    cmp("grant_clr", 64'h0, 64'(grant));
  endtask : t_bo
  task t_pause;
    burst <= 1'b1;
    blen  <= 16'h07D0;
    @(posedge clk_sys_i);
    burst <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    load(2'h3, 10'h001);
    repeat (1500) @(posedge clk_sys_i);
    cmp("grant_busy", 64'h0, 64'(grant));
    repeat (2000) if (grant === 4'h0) @(posedge clk_sys_i);
    cmp("grant_idle", 64'h8, 64'(grant));
    give_ack();
  endtask : t_pause
  task t_arb;
    load(2'h0, 10'h001);
    load(2'h2, 10'h001);
    repeat (2000) if (grant === 4'h0) @(posedge clk_sys_i);
    g = grant;
    cmp("one_grant", 64'h1, 64'($countones(g)));
    give_ack();
    repeat (2000) if (grant === 4'h0) @(posedge clk_sys_i);
    cmp("both_grants", 64'h5, 64'(g | grant));
    give_ack();
  endtask : t_arb
  // Pointer sits at 0 after four acks; one more moves the rotated start to 1
  task t_rr;
    pol <= wmcat_pkg::WMCAT_POL_ROUND;
    load(2'h1, 10'h001);
    repeat (2000) if (grant === 4'h0) @(posedge clk_sys_i);
    cmp("rr_single", 64'h2, 64'(grant));
    give_ack();
    repeat (400) if (slot !== 1'b1) @(posedge clk_sys_i);
    cmp("slot_trig", 64'h1, 64'(slot));
    load(2'h0, 10'h001);
    load(2'h2, 10'h001);
    repeat (2000) if (grant === 4'h0) @(posedge clk_sys_i);
    cmp("rr_first", 64'h1, 64'(grant));
    give_ack();
    repeat (2000) if (grant === 4'h0) @(posedge clk_sys_i);
    cmp("rr_second", 64'h4, 64'(grant));
    give_ack();
    pol <= wmcat_pkg::WMCAT_POL_FIXED;
  endtask : t_rr
  task t_nav;
    nupd <= 1'b1;
    ndur <= 16'h0005;
    @(posedge clk_sys_i);
    nupd <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    cmp("nav_busy", 64'h1, 64'(navb));
    cmp("medium_idle", 64'h0, 64'(midle));
    repeat (240) @(posedge clk_sys_i);
    cmp("nav_done", 64'h0, 64'(navb));
  endtask : t_nav
  task t_tsf;
    tsl  <= '{1'b1, 64'h1000};
    tbtt <= 64'h1008;
    @(posedge clk_sys_i);
    tsl <= '0;
    repeat (3) @(posedge clk_sys_i);
    cmp("tsf_load", 64'h1, 64'(tsf >= 64'h1000 && tsf <= 64'h1001));
    repeat (600) if (tbo !== 1'b1) @(posedge clk_sys_i);
    cmp("tbtt", 64'h1, 64'(tbo));
    repeat (300) if (trig[0] !== 1'b1) @(posedge clk_sys_i);
    cmp("offset_trig", 64'h1, 64'(trig[0]));
  endtask : t_tsf
  task t_sleep;
    b = tsf;
    sgo  <= 1'b1;
    scnt <= 32'h3;
    @(posedge clk_sys_i);
    sgo <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    cmp("clk_off", 64'h0, 64'(clken));
    repeat (400) if (wake !== 1'b1) @(posedge clk_sys_i);
    cmp("wake", 64'h1, 64'(wake));
    repeat (3) @(posedge clk_sys_i);
    cmp("clk_on", 64'h1, 64'(clken));
    cmp("tsf_adv", 64'h1, 64'(tsf - b >= 64'h3 && tsf - b <= 64'h5));
  endtask : t_sleep
  task t_coex;
    mode <= 3'h2;
    fsel <= 1'b1;
    mwr  <= 1'b1;
    @(posedge clk_sys_i);
    mwr  <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    cmp("pin_mode", 64'h2, 64'(mo));
    cmp("freq_sel", 64'h1, 64'(fso));
    mode <= 3'h7;
    mwr  <= 1'b1;
    peer_cmd <= 3'h7;
    permit <= 1'b1;
    @(posedge clk_sys_i);
    mwr <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    cmp("coex_status", 64'h7, 64'(st));
    cmp("tx_permit", 64'h1, 64'(txp));
    do_reset();
    cmp("mode_rst", 64'h7, 64'(mo));
    cmp("freq_rst", 64'h0, 64'(fso));
  endtask : t_coex
  // ==========================================================
  // Sequence and watchdog
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      complete_run();
    end
  end
  initial
  begin
    {burst, ack, nupd, sgo, mwr, permit, fsel} = 7'h00;
    blen = 16'h0;
    ndur = 16'h0;
    peer_cmd = 3'h0;
    mode = 3'h7;
    pol = wmcat_pkg::WMCAT_POL_FIXED;
    bol = '0;
    txr = '0;
    tsl = '0;
    tbtt = 64'hFFFF_FFFF_FFFF_FFFF;
    scnt = 32'h0;
    toff[0] = 64'h2;
    toff[1] = 64'h3;
    do_reset();
    cmp("mode_init", 64'h7, 64'(mo));
    cmp("clk_en_init", 64'h1, 64'(clken));
    t_ifs();
    t_bo();
    t_pause();
    t_arb();
    t_rr();
    t_nav();
    t_tsf();
    t_sleep();
    t_coex();
    complete_run();
  end
endmodule : wmcat_top_tb_top
bind wmcat_top wmcat_checker wmcat_checker_inst (.clk_sys_i, .rst_i, .phy_busy_i,
  .grant_ack_i, .nav_upd_i, .nav_dur_i, .coex_pin_mode_i, .coex_mode_wr_i, .bo_grant_o,
  .sifs_trig_o, .rifs_trig_o, .tx_go_o, .nav_busy_o, .coex_pin_mode_o, .coex_freq_sel_o,
  .wake_o, .tbtt_o);
`default_nettype wire
